// file: logic/pdcr_params.svh
`ifndef PDCR_PARAMS_SVH
`define PDCR_PARAMS_SVH

`define PDCR_ADDR_DEV_CAP   12'hC4
`define PDCR_ADDR_DEV_CTRL  12'hC8
`define PDCR_ADDR_ERR_FLAGS 12'h100

`define PDCR_MPS_128        3'h0
`define PDCR_MPS_256        3'h1
`define PDCR_MPS_512        3'h2

`define PDCR_TYPE_UP        4'h5
`define PDCR_TYPE_DOWN      4'h6

`define PDCR_RST_MPS_SUP    3'h1
`define PDCR_RST_RBER       1'h1
`define PDCR_RST_MPS        3'h0
`define PDCR_RST_SPL_VAL    8'h00
`define PDCR_RST_SPL_SCL    2'h0

`define PDCR_CAP_MPS_LSB    0
`define PDCR_CAP_RBER_BIT   15
`define PDCR_CAP_SPV_LSB    18
`define PDCR_CAP_SPS_LSB    26
`define PDCR_CTL_ERR_LSB    0
`define PDCR_CTL_MPS_LSB    5
`define PDCR_CTL_AUX_BIT    10

`endif

// file: logic/pdcr_pkg.sv
package pdcr_pkg;

  // default values pushed by the serial or EEPROM loader
  typedef struct packed {
    logic [2:0] mps_sup;
    logic       rber;
  } pdcr_dflt_t;

  // payload of a received slot power limit message
  typedef struct packed {
    logic [7:0] value;
    logic [1:0] scale;
  } pdcr_spl_t;

  typedef struct packed {
    logic       corr;
    logic       nonfatal;
    logic       fatal;
    logic       unsup;
  } pdcr_err_t;

  typedef enum logic [1:0] {
    PDCR_WAIT1 = 2'b00,
    PDCR_WAIT2 = 2'b01,
    PDCR_RUN   = 2'b10
  } pdcr_cap_state_t;

endpackage

// file: logic/pdcr_regs.sv
`timescale 1ns/1ps
`include "pdcr_params.svh"

module pdcr_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire logic                large_payload_strap,
  input  wire logic                upstream_strap,
  input  wire logic                dflt_valid,
  input  wire pdcr_pkg::pdcr_dflt_t dflt,
  input  wire logic                spl_valid,
  input  wire pdcr_pkg::pdcr_spl_t spl_msg,
  input  wire pdcr_pkg::pdcr_err_t err_event,
  output logic [3:0]               port_type,
  output logic [2:0]               max_payload,
  output logic                     aux_pm_enable,
  output pdcr_pkg::pdcr_err_t      err_report
);
  import pdcr_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // clamp a payload code to the supported limit
  function automatic logic [2:0] clamp_mps(input logic [2:0] req,
                                           input logic [2:0] lim);
    clamp_mps = (req > lim) ? lim : req;
  endfunction

  function automatic logic legal_mps(input logic [2:0] code);
    legal_mps = (code <= `PDCR_MPS_512);
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] strap_sync;
  logic [1:0] up_sync;

  always_ff @(posedge core_clk) begin
    strap_sync <= {strap_sync[0], large_payload_strap};
    up_sync    <= {up_sync[0], upstream_strap};
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  pdcr_cap_state_t cap_state;
  pdcr_cap_state_t next_cap_state;
  logic [2:0]      mps_sup;
  logic            rber;
  logic            is_up;
  logic [7:0]      spl_value;
  logic [1:0]      spl_scale;
  logic [3:0]      err_en;
  logic [2:0]      mps;
  logic            aux_en;
  pdcr_err_t       err_flags;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire        setup    = psel & ~penable;
  wire        access   = psel & penable & pready;
  wire        wr       = access & pwrite;
  wire        hit_cap  = (paddr == ADDR_W'(`PDCR_ADDR_DEV_CAP));
  wire        hit_ctl  = (paddr == ADDR_W'(`PDCR_ADDR_DEV_CTRL));
  wire        hit_err  = (paddr == ADDR_W'(`PDCR_ADDR_ERR_FLAGS));
  wire        mapped   = hit_cap | hit_ctl | hit_err;
  wire        wr_ctl0  = wr & hit_ctl & pstrb[0];
  wire        wr_ctl1  = wr & hit_ctl & pstrb[1];
  wire        wr_err   = wr & hit_err & pstrb[0];
  wire        running  = (cap_state == PDCR_RUN);
  wire        dflt_ok  = dflt_valid & running & legal_mps(dflt.mps_sup);
  wire [2:0]  lim_now  = dflt_ok ? dflt.mps_sup : mps_sup;

  // fixed-zero fields come straight from the zero fill
  wire [31:0] cap_word = {4'h0,
                          spl_scale,
                          spl_value,
                          2'h0,
                          rber,
                          3'h0,
                          3'h0,
                          3'h0,
                          1'h0,
                          2'h0,
                          mps_sup};
  wire [31:0] ctl_word = {16'h0000,
                          1'h0,
                          3'h0,
                          1'h0,
                          aux_en,
                          2'h0,
                          mps,
                          1'h0,
                          err_en};
  wire [31:0] err_word = {28'h0000000, err_flags};
  wire [31:0] rd_word  = hit_cap ? cap_word :
                         hit_ctl ? ctl_word :
                         hit_err ? err_word : 32'h00000000;

  wire [2:0]  wr_mps   = clamp_mps(pwdata[7:5], lim_now);
  wire [3:0]  err_clr  = wr_err ? pwdata[3:0] : 4'h0;
  wire [3:0]  next_err = err_event | (err_flags & ~err_clr);
  // enables count correctable from bit 0, the event struct from its msb
  wire [3:0]  rpt_en   = {err_en[0], err_en[1], err_en[2], err_en[3]};

  // ------------------------------------------------------------
  // apb slave: one wait-free access phase, data registered at setup
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h00000000 : rd_word;
        pslverr <= ~mapped;
      end else if (access) begin
        prdata  <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // strap capture after reset release
  // ------------------------------------------------------------
  // two idle cycles let the synchronisers settle before sampling
  always_comb begin
    next_cap_state = cap_state;
    unique case (cap_state)
      PDCR_WAIT1: next_cap_state = PDCR_WAIT2;
      PDCR_WAIT2: next_cap_state = PDCR_RUN;
      PDCR_RUN:   next_cap_state = PDCR_RUN;
      default:    next_cap_state = PDCR_WAIT1;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cap_state <= PDCR_WAIT1;
    end else begin
      cap_state <= next_cap_state;
    end
  end

  // ------------------------------------------------------------
  // capabilities fields
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mps_sup <= `PDCR_RST_MPS_SUP;
      rber    <= `PDCR_RST_RBER;
      is_up   <= 1'b1;
    end else if (cap_state == PDCR_WAIT2) begin
      mps_sup <= strap_sync[1] ? `PDCR_MPS_512 : `PDCR_MPS_256;
      is_up   <= up_sync[1];
    end else if (dflt_ok) begin
      mps_sup <= dflt.mps_sup;
      rber    <= dflt.rber;
    end
  end

  // slot power fields only follow the message on the upstream port
  always_ff @(posedge core_clk) begin
    if (reset) begin
      spl_value <= `PDCR_RST_SPL_VAL;
      spl_scale <= `PDCR_RST_SPL_SCL;
    end else if (spl_valid & is_up & running) begin
      spl_value <= spl_msg.value;
      spl_scale <= spl_msg.scale;
    end
  end

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  // only these fields and mps take control writes; every other control bit drops the data
  always_ff @(posedge core_clk) begin
    if (reset) begin
      err_en <= 4'h0;
      aux_en <= 1'b0;
    end else begin
      if (wr_ctl0) begin
        err_en <= pwdata[3:0];
      end
      if (wr_ctl1) begin
        aux_en <= pwdata[`PDCR_CTL_AUX_BIT];
      end
    end
  end

  // a lowered limit also pulls the stored setting down
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mps <= `PDCR_RST_MPS;
    end else if (wr_ctl0) begin
      mps <= wr_mps;
    end else begin
      mps <= clamp_mps(mps, lim_now);
    end
  end

  // ------------------------------------------------------------
  // error flags and reporting
  // ------------------------------------------------------------
  // a new error in the clearing cycle keeps its flag set
  always_ff @(posedge core_clk) begin
    if (reset) begin
      err_flags  <= '0;
      err_report <= '0;
    end else begin
      err_flags  <= next_err;
      err_report <= err_event & rpt_en;
    end
  end

  // ------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port_type     <= `PDCR_TYPE_UP;
      max_payload   <= `PDCR_RST_MPS;
      aux_pm_enable <= 1'b0;
    end else begin
      port_type     <= is_up ? `PDCR_TYPE_UP : `PDCR_TYPE_DOWN;
      max_payload   <= mps;
      aux_pm_enable <= aux_en;
    end
  end

endmodule // pdcr_regs

// file: bench/pdcr_regs_assertions.sv
`timescale 1ns/1ps
`include "pdcr_params.svh"
// ----------------
// bus and field checks
// ----------------
module pdcr_regs_chk
  import pdcr_pkg::*;
#(parameter int ADDR_W = 12) (
  input wire logic                core_clk,
  input wire logic                reset,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [3:0]          pstrb,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  input wire logic [3:0]          port_type,
  input wire logic [2:0]          max_payload,
  input wire logic                aux_pm_enable,
  input wire pdcr_pkg::pdcr_err_t err_event,
  input wire pdcr_pkg::pdcr_err_t err_report
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire rd = psel && penable && pready && !pwrite;
  wire wr_aux = psel && penable && pready && pwrite && paddr == `PDCR_ADDR_DEV_CTRL && pstrb[1];
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  ready_follows_a: assert property (setup_s |=> access_s) else $error("no ready");
  ready_single_a: assert property (pready |=> !pready) else $error("ready held");
  slverr_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("slverr");
  cap_fixed_a: assert property (rd && paddr == `PDCR_ADDR_DEV_CAP |->
    (prdata & 32'hF003_7FF8) == 32'h0 && prdata[2:0] <= 3'h2) else $error("cap bits");
  ctl_fixed_a: assert property (rd && paddr == `PDCR_ADDR_DEV_CTRL |->
    (prdata & 32'hFFFF_FB10) == 32'h0) else $error("ctl bits");
  payload_clamp_a: assert property (max_payload <= 3'h2) else $error("payload");
  port_kind_a: assert property (port_type == 4'h5 || port_type == 4'h6) else $error("type");
  aux_cause_a: assert property ($changed(aux_pm_enable) |-> $past(wr_aux, 2)) else $error("aux");
  err_cause_a: assert property ((err_report & ~($past(err_event) | $past(err_event, 2))) == 4'h0)
    else $error("report");
endmodule // pdcr_regs_chk

bind pdcr_regs pdcr_regs_chk #(.ADDR_W(ADDR_W)) i_chk (.core_clk, .reset, .psel, .penable,
  .pwrite, .paddr, .pstrb, .pready, .prdata, .pslverr, .port_type, .max_payload,
  .aux_pm_enable, .err_event, .err_report);

// file: bench/pdcr_uplink.sv
`timescale 1ns/1ps
// ----------------
// upstream link side: messages, loader, error events
// ----------------
module pdcr_uplink (
  input  wire logic            core_clk,
  output logic                 spl_valid = 1'b0,
  output pdcr_pkg::pdcr_spl_t  spl_msg = '0,
  output logic                 dflt_valid = 1'b0,
  output pdcr_pkg::pdcr_dflt_t dflt = '0,
  output pdcr_pkg::pdcr_err_t  err_event = '0
);
  import pdcr_pkg::*;
  // payloads are scrambled after the pulse, never left looking valid
  task automatic send_spl(input pdcr_spl_t m);
    @(posedge core_clk);
    spl_valid <= 1'b1;
    spl_msg <= m;
    @(posedge core_clk);
    spl_valid <= 1'b0;
    spl_msg <= ~m;
  endtask
  task automatic send_dflt(input pdcr_dflt_t d);
    @(posedge core_clk);
    dflt_valid <= 1'b1;
    dflt <= d;
    @(posedge core_clk);
    dflt_valid <= 1'b0;
    dflt <= ~d;
  endtask
  task automatic send_err(input pdcr_err_t e);
    @(posedge core_clk);
    err_event <= e;
    @(posedge core_clk);
    err_event <= '0;
  endtask
endmodule // pdcr_uplink

// file: bench/pcie_device_cap_ctrl_regs_tb.sv
`timescale 1ns/1ps
module pcie_device_cap_ctrl_regs_tb;
  import pdcr_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, aux_pm_enable, spl_valid, dflt_valid;
  logic large_payload_strap = 1'b0, upstream_strap = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hF, port_type;
  logic [2:0]  max_payload;
  pdcr_dflt_t  dflt;
  pdcr_spl_t   spl_msg;
  pdcr_err_t   err_event, err_report;
  logic [32:0] exq[$];
  int          err_count = 0, samples_checked = 0, seed = 95308;

  initial forever #5 core_clk = ~core_clk;
  pdcr_regs i_dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .large_payload_strap, .upstream_strap, .dflt_valid, .dflt, .spl_valid,
    .spl_msg, .err_event, .port_type, .max_payload, .aux_pm_enable, .err_report);
  pdcr_uplink i_up (.core_clk, .spl_valid, .spl_msg, .dflt_valid, .dflt, .err_event);

  // ----------------
  // checking and bus tasks
  // ----------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // reads note the expected {pslverr, prdata}; the monitor compares
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    if (!w) exq.push_back(e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, exq.size() > 0 ? exq.pop_front() : 33'h1_FFFF_FFFF);
  end

  // ----------------
  // main sequence: upstream pass, then downstream pass
  // ----------------
  initial begin
    logic [31:0] cap, ctl, r;
    logic [2:0]  sup, mp;
    logic [3:0]  ev, seen;
    for (int p = 0; p < 2; p++) begin
      @(posedge core_clk);
      reset <= 1'b1;
      upstream_strap <= (p == 0);
      large_payload_strap <= (p == 0) ? 1'($random(seed)) : ~large_payload_strap;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      repeat (5) @(posedge core_clk);
      sup = large_payload_strap ? 3'h2 : 3'h1;
      cap = {16'h0, 1'b1, 12'h0, sup};
      apb(1'b0, 12'hC4, 32'h0, {1'b0, cap});
      chk(33'(port_type), (p == 0) ? 33'h5 : 33'h6);
      apb(1'b0, 12'hC8, 32'h0, 33'h0);
      apb(1'b1, 12'hC8, 32'hFFFF_FFFF, 33'h0);
      apb(1'b0, 12'hC8, 32'h0, {1'b0, 32'h40F | {sup, 5'h0}});
      repeat (2) @(negedge core_clk);
      chk(33'({max_payload, aux_pm_enable}), 33'({sup, 1'b1}));
      apb(1'b1, 12'hC4, 32'hFFFF_FFFF, 33'h0);
      apb(1'b0, 12'hC4, 32'h0, {1'b0, cap});
      apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
      i_up.send_dflt({3'h5, 1'b0});
      apb(1'b0, 12'hC4, 32'h0, {1'b0, cap});
      i_up.send_dflt({3'h0, 1'b0});
      apb(1'b0, 12'hC4, 32'h0, 33'h0);
      apb(1'b0, 12'hC8, 32'h0, 33'h40F);
      i_up.send_dflt({sup, 1'b1});
      r = $random(seed);
      i_up.send_spl(r[9:0]);
      if (p == 0) cap[27:18] = {r[1:0], r[9:2]};
      apb(1'b0, 12'hC4, 32'h0, {1'b0, cap});
      ctl = $random(seed);
      apb(1'b1, 12'hC8, ctl, 33'h0);
      mp = (ctl[7:5] > sup) ? sup : ctl[7:5];
      apb(1'b0, 12'hC8, 32'h0, {22'h0, ctl[10], 2'h0, mp, 1'b0, ctl[3:0]});
      ev = 4'($random(seed)) | 4'h1;
      i_up.send_err(ev);
      seen = 4'h0;
      repeat (4) begin
        @(negedge core_clk);
        seen = seen | err_report;
      end
      chk(33'(seen), 33'(ev & {ctl[0], ctl[1], ctl[2], ctl[3]}));
      apb(1'b0, 12'h100, 32'h0, {29'h0, ev});
      apb(1'b1, 12'h100, 32'hF, 33'h0);
      apb(1'b0, 12'h100, 32'h0, 33'h0);
      $display("pass %0d finished", p);
    end
    wrap_up();
  end
endmodule // pcie_device_cap_ctrl_regs_tb
